//--- pkg/canr_pkg.sv
// Shared constants, field layouts and carrier types of the advertisement and partner registers
package canr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_ADV = 6'h04;
  localparam logic [5:0] IDX_LP = 6'h05;
  localparam logic [5:0] IDX_CTRL = 6'h08;
  localparam logic [5:0] IDX_IRQ_STAT = 6'h09;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h0A;
  localparam logic [5:0] IDX_STATUS = 6'h0B;
  localparam int ADDR_W = 8;

  // Advertisement and partner register fields
  localparam int ADV_FD10_BIT = 6;
  localparam int ADV_HD10_BIT = 5;
  localparam int SEL_W = 5;
  localparam logic [4:0] SEL_RST = 5'h01;
  localparam logic [15:0] LP_RST = 16'h0000;
  localparam int STRAP_ADV_BIT = 1;

  // Control register fields
  localparam int CTRL_SWRST_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int CTRL_ANEG_BIT = 2;
  localparam int CTRL_SPD_LO_BIT = 3;
  localparam int CTRL_SPD_HI_BIT = 4;
  localparam int CTRL_DUPLEX_BIT = 5;
  localparam int CTRL_PD_BIT = 6;
  localparam int CTRL_PD2_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h24;
  localparam logic [1:0] SPEED_1000 = 2'h2;
  localparam logic [1:0] GIG_ADV_FULL = 2'h2;
  localparam logic [1:0] GIG_ADV_HALF = 2'h1;

  // Interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_PAGE_BIT = 0;
  localparam int IRQ_LINKDN_BIT = 1;
  localparam int IRQ_APPLY_BIT = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } canr_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } canr_apb_rsp_s;

  // Received base page as laid out in the partner ability register
  typedef struct packed {
    logic next_page;
    logic ack;
    logic remote_fault;
    logic tech12;
    logic asym_pause;
    logic pause;
    logic t4;
    logic tx_fd;
    logic tx_hd;
    logic t10_fd;
    logic t10_hd;
    logic [4:0] selector;
  } canr_lp_s;

endpackage

//--- hw/canr_apb_slave.sv
// APB slave front end: zero-wait access, registered read data and error
`timescale 1ns/1ps
module canr_apb_slave (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB
  input wire canr_pkg::canr_apb_req_s apb_req,
  output canr_pkg::canr_apb_rsp_s apb_rsp,
  // Register side
  input wire logic [31:0] reg_rdata,
  input wire logic reg_hit,
  output logic [5:0] reg_idx,
  output logic reg_wr,
  output logic [31:0] reg_wdata
);
  import canr_pkg::*;

  logic [31:0] rdata_q;
  logic err_q;
  logic setup;
  logic access;

  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign reg_idx = apb_req.paddr[ADDR_W-1:2];
  assign reg_wdata = apb_req.pwdata;
  // Unmapped or misaligned addresses are refused and never write
  assign reg_wr = access && apb_req.pwrite && reg_hit && (apb_req.paddr[1:0] == 2'h0);

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= apb_req.pwrite ? 32'h00000000 : reg_rdata;
      err_q <= !reg_hit || (apb_req.paddr[1:0] != 2'h0);
    end
  end

  assign apb_rsp.prdata = rdata_q;
  assign apb_rsp.pready = access;
  assign apb_rsp.pslverr = access && err_q;

endmodule

//--- hw/canr_regs.sv
// Copper auto-negotiation advertisement and link partner base page registers
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module canr_regs #(
  parameter int STRAP_W = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB
  input wire canr_pkg::canr_apb_req_s apb_req,
  output canr_pkg::canr_apb_rsp_s apb_rsp,
  // Strap pins
  input wire logic [STRAP_W-1:0] negotiation_config_strap,
  // Negotiation engine
  input wire logic copper_link_up,
  input wire logic page_rx_valid,
  input wire logic [15:0] page_rx_word,
  input wire logic [1:0] gig_adv_in,
  output logic [6:0] adv_word,
  output logic [1:0] gig_adv,
  output logic forced_1000,
  output logic restart_aneg,
  // Interrupt
  output logic irq
);
  import canr_pkg::*;

  if (STRAP_W <= STRAP_ADV_BIT) begin : g_chk
    $error("canr_regs: strap too narrow for advertise bit");
  end

  logic [STRAP_W-1:0] strap_m;
  logic [STRAP_W-1:0] strap_s;
  logic [1:0] adv10_pend;
  logic [1:0] adv10_act;
  logic [SEL_W-1:0] sel;
  canr_lp_s lp;
  logic [7:0] ctrl;
  logic sw_rst;
  logic restart;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_evt;
  logic link_q;
  logic pd_q;
  logic pd2_q;
  logic upd_evt;
  logic link_down;
  logic pd_exit;
  logic next_forced;
  logic [5:0] reg_idx;
  logic reg_wr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_hit;

  canr_apb_slave u_apb (
    .clk_sys(clk_sys),
    .srst(srst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .reg_idx(reg_idx),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata)
  );

  function automatic logic wr_to(input logic [5:0] idx);
    return reg_wr && (reg_idx == idx);
  endfunction

  // Strap pins come from outside the clock domain
  always_ff @(posedge clk_sys) begin
    strap_m <= negotiation_config_strap;
    strap_s <= strap_m;
  end

  // Control register; reset and restart bits are one-cycle commands
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl <= CTRL_RST;
      sw_rst <= 1'b0;
      restart <= 1'b0;
    end else begin
      sw_rst <= wr_to(IDX_CTRL) && reg_wdata[CTRL_SWRST_BIT];
      restart <= wr_to(IDX_CTRL) && reg_wdata[CTRL_RESTART_BIT];
      if (wr_to(IDX_CTRL)) begin
        ctrl <= reg_wdata[7:0];
        ctrl[CTRL_SWRST_BIT] <= 1'b0;
        ctrl[CTRL_RESTART_BIT] <= 1'b0;
      end
    end
  end

  // Edge history for link loss and power-down exit
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_q <= 1'b0;
      pd_q <= 1'b0;
      pd2_q <= 1'b0;
    end else begin
      link_q <= copper_link_up;
      pd_q <= ctrl[CTRL_PD_BIT];
      pd2_q <= ctrl[CTRL_PD2_BIT];
    end
  end

  assign link_down = link_q && !copper_link_up;
  assign pd_exit = (pd_q && !ctrl[CTRL_PD_BIT]) || (pd2_q && !ctrl[CTRL_PD2_BIT]);
  assign upd_evt = sw_rst || restart || pd_exit || link_down;

  // Pending and active 10BASE-T advertise bits
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      adv10_pend <= {2{strap_s[STRAP_ADV_BIT]}};
    end else if (wr_to(IDX_ADV)) begin
      adv10_pend <= reg_wdata[ADV_FD10_BIT:ADV_HD10_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      adv10_act <= {2{strap_s[STRAP_ADV_BIT]}};
    end else if (upd_evt) begin
      adv10_act <= adv10_pend;
    end
  end

  // Selector takes writes at once and ignores the software reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel <= SEL_RST;
    end else if (wr_to(IDX_ADV)) begin
      sel <= reg_wdata[SEL_W-1:0];
    end
  end

  // Partner base page, cleared by either reset, loaded on each new page
  always_ff @(posedge clk_sys) begin
    if (srst || sw_rst) begin
      lp <= LP_RST;
    end else if (page_rx_valid) begin
      lp.next_page <= page_rx_word[15];
      lp.ack <= page_rx_word[14];
      lp.remote_fault <= page_rx_word[13];
      lp.tech12 <= page_rx_word[12];
      lp.asym_pause <= page_rx_word[11];
      lp.pause <= page_rx_word[10];
      lp.t4 <= page_rx_word[9];
      lp.tx_fd <= page_rx_word[8];
      lp.tx_hd <= page_rx_word[7];
      lp.t10_fd <= page_rx_word[6];
      lp.t10_hd <= page_rx_word[5];
      lp.selector <= page_rx_word[4:0];
    end
  end

  // Forced gigabit override of the advertised abilities
  assign next_forced = !ctrl[CTRL_ANEG_BIT]
    && ({ctrl[CTRL_SPD_HI_BIT], ctrl[CTRL_SPD_LO_BIT]} == SPEED_1000);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      forced_1000 <= 1'b0;
      adv_word <= {2'h0, SEL_RST};
      gig_adv <= 2'h0;
      restart_aneg <= 1'b0;
    end else begin
      forced_1000 <= next_forced;
      restart_aneg <= upd_evt;
      if (next_forced) begin
        adv_word <= {2'h0, sel};
        gig_adv <= ctrl[CTRL_DUPLEX_BIT] ? GIG_ADV_FULL : GIG_ADV_HALF;
      end else begin
        adv_word <= {adv10_act, sel};
        gig_adv <= gig_adv_in;
      end
    end
  end

  // Interrupt status: set wins over a write-one clear in the same cycle
  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_PAGE_BIT] = page_rx_valid;
    irq_evt[IRQ_LINKDN_BIT] = link_down;
    irq_evt[IRQ_APPLY_BIT] = upd_evt;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_stat <= IRQ_RST;
    end else if (wr_to(IDX_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_mask <= IRQ_RST;
    end else if (wr_to(IDX_IRQ_MASK)) begin
      irq_mask <= reg_wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // Read decode; writes to read-only registers are ignored
  always_comb begin
    reg_rdata = 32'h00000000;
    reg_hit = 1'b1;
    unique case (reg_idx)
      IDX_ADV: begin
        reg_rdata[ADV_FD10_BIT:ADV_HD10_BIT] = adv10_pend;
        reg_rdata[SEL_W-1:0] = sel;
      end
      IDX_LP: reg_rdata[15:0] = lp;
      IDX_CTRL: reg_rdata[7:0] = ctrl;
      IDX_IRQ_STAT: reg_rdata[IRQ_W-1:0] = irq_stat;
      IDX_IRQ_MASK: reg_rdata[IRQ_W-1:0] = irq_mask;
      IDX_STATUS: reg_rdata[4:0] = {gig_adv, adv10_act, forced_1000};
      default: reg_hit = 1'b0;
    endcase
  end

  // Write decode is spelled out below so that assertions see sampled values
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  pend_hold_a: assert property (
    !upd_evt |=> adv10_act == $past(adv10_act))
    else $error("10BASE-T advertise changed without an update event");

  pend_apply_a: assert property (
    upd_evt |=> adv10_act == $past(adv10_pend))
    else $error("pending 10BASE-T advertise not applied on update event");

  pend_wait_a: assert property (
    reg_wr && reg_idx == IDX_ADV && !upd_evt ##1 !upd_evt |=> adv10_act == $past(adv10_act, 2))
    else $error("10BASE-T advertise write took effect early");

  strap_load_a: assert property (
    $fell(srst) |-> adv10_act == {2{$past(strap_s[STRAP_ADV_BIT])}})
    else $error("10BASE-T advertise not loaded from strap");

  forced_gig_a: assert property (
    next_forced |=> forced_1000 && gig_adv == ($past(ctrl[CTRL_DUPLEX_BIT]) ? 2'h2 : 2'h1))
    else $error("forced gigabit advertisement wrong");

  forced_ign_a: assert property (
    next_forced |=> adv_word[6:5] == 2'h0)
    else $error("10BASE-T advertised while forced to gigabit");

  sel_keep_a: assert property (
    sw_rst && !(reg_wr && reg_idx == IDX_ADV) |=> sel == $past(sel))
    else $error("selector lost on software reset");

  lp_clear_a: assert property (
    sw_rst |=> lp == 16'h0000)
    else $error("partner page not cleared on software reset");

  lp_ro_a: assert property (
    reg_wr && reg_idx == IDX_LP && !page_rx_valid && !sw_rst |=> $stable(lp))
    else $error("partner page changed by a register write");

  lp_load_a: assert property (
    page_rx_valid && !sw_rst |=> lp == $past(page_rx_word))
    else $error("partner page not updated from received word");

  irq_page_a: assert property (
    page_rx_valid && irq_mask[IRQ_PAGE_BIT] |=> irq [*2])
    else $error("page interrupt not raised or not held");

endmodule

//--- verif/canr_lp_model.sv
// Link partner model: delivers received base pages and drops the copper link
`timescale 1ns/1ps
module canr_lp_model (
  // Clock
  input wire logic clk_sys,
  // Toward the register block
  output logic page_rx_valid,
  output logic [15:0] page_rx_word,
  output logic copper_link_up
);
  initial begin
    page_rx_valid = 1'b0;
    page_rx_word = 16'h0000;
    copper_link_up = 1'b1;
  end

  // One-cycle page strobe; the word turns to garbage once the strobe is gone
  task automatic send_page(input logic [15:0] w);
    @(posedge clk_sys);
    page_rx_valid <= 1'b1;
    page_rx_word <= w;
    @(posedge clk_sys);
    page_rx_valid <= 1'b0;
    page_rx_word <= ~w;
  endtask

  task automatic drop_link();
    @(posedge clk_sys);
    copper_link_up <= 1'b0;
    @(posedge clk_sys);
    copper_link_up <= 1'b1;
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench for the advertisement and partner ability registers
`timescale 1ns/1ps
module tb_top;
  import canr_pkg::*;
  localparam logic [7:0] A_ADV = {IDX_ADV, 2'b00};
  localparam logic [7:0] A_LP = {IDX_LP, 2'b00};
  localparam logic [7:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [7:0] A_ST = {IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] A_MK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] A_SR = {IDX_STATUS, 2'b00};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [1:0] strap = 2'b10;
  logic [1:0] gig_in = 2'h0;
  canr_apb_req_s req = '0;
  canr_apb_rsp_s rsp;
  logic page_rx_valid, copper_link_up, forced_1000, restart_aneg, irq;
  logic [15:0] page_rx_word;
  logic [6:0] adv_word;
  logic [1:0] gig_adv;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n_rst = 0;
  int m_act, m_sel, m_lp;

  always #12.5 clk_sys = ~clk_sys;

  canr_regs canr_regs_i (.clk_sys(clk_sys), .srst(srst), .apb_req(req), .apb_rsp(rsp),
    .negotiation_config_strap(strap), .copper_link_up(copper_link_up),
    .page_rx_valid(page_rx_valid), .page_rx_word(page_rx_word), .gig_adv_in(gig_in),
    .adv_word(adv_word), .gig_adv(gig_adv), .forced_1000(forced_1000),
    .restart_aneg(restart_aneg), .irq(irq));
  canr_lp_model canr_lp_model_i (.clk_sys(clk_sys), .page_rx_valid(page_rx_valid),
    .page_rx_word(page_rx_word), .copper_link_up(copper_link_up));

  task automatic final_report();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle precedes each setup
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'b1;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (restart_aneg === 1'b1) n_rst <= n_rst + 1;
    if (cyc == 6000) begin
      n_fail++;
      final_report();
    end
  end

  initial begin
    int i, p, d;
    logic [15:0] w;
    void'($urandom(53));
    m_sel = 1;
    m_lp = 0;
    m_act = 3;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    rd_chk(A_ADV, 32'h61);
    rd_chk(A_LP, 32'h0);
    chk(adv_word, m_act * 32 + m_sel);
    apb(A_MK, 1'b1, 32'h1);
    for (i = 0; i < 6; i++) begin
      w = (i == 0) ? 16'hFFFF : 16'($urandom);
      canr_lp_model_i.send_page(w);
      m_lp = w;
      rd_chk(A_LP, m_lp);
    end
    apb(A_LP, 1'b1, ~m_lp);
    rd_chk(A_LP, m_lp);
    @(negedge clk_sys);
    chk(irq, 1'b1);
    apb(A_ST, 1'b1, 32'h7);
    apb(A_MK, 1'b1, 32'h0);
    canr_lp_model_i.send_page(16'h00A1);
    m_lp = 16'h00A1;
    @(negedge clk_sys);
    chk(irq, 1'b0);
    apb(8'h3C, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    apb(8'h11, 1'b1, 32'h1F);
    chk(32'(err), 32'h1);
    rd_chk(A_ADV, 32'h61);
    // Each update event in turn: sw reset, restart, both power-down exits, link loss
    for (i = 0; i < 5; i++) begin
      p = (m_act + 1 + $urandom % 3) % 4;
      m_sel = $urandom % 32;
      apb(A_ADV, 1'b1, p * 32 + m_sel);
      rd_chk(A_ADV, p * 32 + m_sel);
      @(negedge clk_sys);
      chk(adv_word, m_act * 32 + m_sel);
      case (i)
        0: apb(A_CTRL, 1'b1, 32'h25);
        1: apb(A_CTRL, 1'b1, 32'h26);
        2, 3: begin
          apb(A_CTRL, 1'b1, (i == 2) ? 32'h64 : 32'hA4);
          apb(A_CTRL, 1'b1, 32'h24);
        end
        default: canr_lp_model_i.drop_link();
      endcase
      m_act = p;
      settle();
      chk(adv_word, m_act * 32 + m_sel);
      if (i == 0) rd_chk(A_LP, 32'h0);
    end
    chk(n_rst, 32'h5);
    rd_chk(A_ST, 32'h7);
    apb(A_ST, 1'b1, 32'h2);
    rd_chk(A_ST, 32'h5);
    for (d = 0; d < 2; d++) begin
      apb(A_CTRL, 1'b1, 32'h10 | (d << 5));
      gig_in <= 2'($urandom);
      settle();
      chk({forced_1000, gig_adv, adv_word}, {1'b1, d ? GIG_ADV_FULL : GIG_ADV_HALF,
        2'b00, 5'(m_sel)});
      rd_chk(A_SR, {27'h0, (d ? GIG_ADV_FULL : GIG_ADV_HALF), 2'(m_act), 1'b1});
    end
    apb(A_CTRL, 1'b1, 32'h24);
    settle();
    chk({forced_1000, gig_adv, adv_word}, {1'b0, gig_in, 2'(m_act), 5'(m_sel)});
    canr_lp_model_i.send_page(16'h1234);
    srst <= 1'b1;
    strap <= 2'b00;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rd_chk(A_ADV, 32'h01);
    rd_chk(A_LP, 32'h0);
    final_report();
  end
endmodule
